// *** hw/msp_status_pins.v ***
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "msp_consts.vh"
// Notes on behaviour
// [RL1] An input pad reports the level an external output drives onto it.
// [RL2] Input pads are read only and return the sampled level at read time.
// [RL3] Output pads drive the last written value; reading returns that value.
// [RL4] Transmit-inhibit pad held low disables the radio transmitter.
// [RL5] Monitor pad is high while transmitting, low once activity ends.
// [RL6] Call-wide mode holds the monitor high for the whole call.
// [RL7] Call-wide mode raises the monitor 300 ms before the first burst.
// [RL8] Call-wide mode drops the monitor 500 ms to 1 s after last burst.
// [RL9] Burst mode makes the monitor follow each transmit burst.
// [RL10] Alarm pad goes high at alarm time, stays high until cleared.
// [RL11] Alarm pad is high throughout reset.
// [RL12] Buzzer pad emits a square wave tone for an external driver.
// [RL13] Over-temperature pad goes high once temperature reaches the maximum.
// [RL14] A pad used for over-temperature loses its alternate function.
// [RL15] Indicator off when device off, steadily on during a call.
// [RL16] Indicator pin level is the inverse of the indicator state.
// [RL17] Registered: indicator blinks, 3 s period, 0.3 s on.
// [RL18] Search or not registered: indicator blinks 1 s period, 0.5 s on.
module msp_status_pins #(
    parameter MS_CYCLES = `MSP_MS_CYCLES,
    parameter TEMP_W = 8
) (
    input wire core_clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [7:0] pad_in,
    output wire [7:0] pad_out,
    output wire [7:0] pad_oe,
    input wire call_active,
    input wire tx_burst,
    input wire tx_burst_soon,
    input wire alarm_due,
    input wire [TEMP_W-1:0] temp_now,
    input wire [1:0] net_state,
    output wire tx_enable,
    output wire network_status_indicator,
    output wire irq
);

    // Pad inputs are asynchronous to the core clock.
    // Pad input synchroniser, first stage read only by the second
    reg [7:0] pad_s1_q;
    reg [7:0] pad_s2_q;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Pads idle high through pull-ups, so start high to avoid a false edge
            pad_s1_q <= 8'hff;
            pad_s2_q <= 8'hff;
        end else begin
            pad_s1_q <= pad_in;
            pad_s2_q <= pad_s1_q; // [RL1]
        end
    end

    // Millisecond tick from the core clock. All slow timing runs off this one
    // enable so the whole block stays on a single clock; the price is that
    // every millisecond figure is only good to one tick.
    reg [31:0] ms_cnt_q;
    wire ms_tick = (ms_cnt_q == MS_CYCLES - 1);
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_cnt_q <= 32'h0000_0000;
        end else if (ms_tick) begin
            ms_cnt_q <= 32'h0000_0000;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
        end
    end

    // Software registers. Only the low bits of each word are kept; the rest
    // read back as zero.
    reg [7:0] mode_q;
    reg [7:0] dir_q;
    reg [7:0] out_q;
    reg [6:0] ctrl_q;
    reg [4:0] mask_q;
    reg [4:0] irq_q;
    reg [TEMP_W-1:0] temp_max_q;
    reg [15:0] buzz_half_q;
    reg alarm_q;
    reg mon_q;
    reg ot_q;

    // Access phase strobes; a transfer takes effect on its single access edge
    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && penable && !pwrite;
    wire mon_burst = ctrl_q[`MSP_CTRL_MON_BURST];
    wire tmon_en = ctrl_q[`MSP_CTRL_TMON_EN];
    wire [2:0] tmon_pad = ctrl_q[`MSP_CTRL_TMON_PAD_HI:`MSP_CTRL_TMON_PAD_LO];

    // Known offsets answer, others raise slave error
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `MSP_OFF_MODE) || (a == `MSP_OFF_DIR) ||
                     (a == `MSP_OFF_OUT) || (a == `MSP_OFF_IN) ||
                     (a == `MSP_OFF_CTRL) || (a == `MSP_OFF_STAT) ||
                     (a == `MSP_OFF_IRQ) || (a == `MSP_OFF_MASK) ||
                     (a == `MSP_OFF_TEMP) || (a == `MSP_OFF_BUZZ);
        end
    endfunction

    // Temperature monitor owns a pad when enabled and pointed at it; this
    // decides both the pad mux and whether the inhibit input is still live
    function ot_owns;
        input en;
        input [2:0] sel;
        input [2:0] pad;
        begin
            ot_owns = en && (sel == pad);
        end
    endfunction

    // An alternate output exists only on the monitor, alarm and buzzer pads;
    // the inhibit pad is an input in alternate mode and never drives
    function alt_drives;
        input [2:0] pad;
        begin
            alt_drives = (pad == `MSP_PAD_MON) || (pad == `MSP_PAD_ALM) ||
                         (pad == `MSP_PAD_BUZ);
        end
    endfunction

    // Nothing here needs time to answer, so the slave never stalls the host
    // Zero wait states keep the host path simple
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= 8'h00;
            dir_q <= 8'h00;
            out_q <= 8'h00;
            ctrl_q <= 7'h00;
            mask_q <= 5'h00;
            temp_max_q <= {TEMP_W{1'b1}};
            buzz_half_q <= 16'h0001;
        end else if (wr_en) begin
            case (paddr)
                `MSP_OFF_MODE: mode_q <= pwdata[7:0];
                `MSP_OFF_DIR: dir_q <= pwdata[7:0];
                `MSP_OFF_OUT: out_q <= pwdata[7:0]; // [RL3]
                `MSP_OFF_CTRL: ctrl_q <= {pwdata[6:2], 1'b0, pwdata[0]};
                `MSP_OFF_MASK: mask_q <= pwdata[4:0];
                `MSP_OFF_TEMP: temp_max_q <= pwdata[TEMP_W-1:0];
                `MSP_OFF_BUZZ: buzz_half_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Dedicated alarm clear is a self-clearing write bit
    wire alarm_clr = wr_en && (paddr == `MSP_OFF_CTRL) && pwdata[`MSP_CTRL_ALM_CLR];

    // A clear landing in the cycle the alarm fires is lost on purpose: dropping
    // a wake-up is worse than a late clear.
    // Alarm latch: reset value high, due wins over clear
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_q <= 1'b1; // [RL11]
        end else if (alarm_due) begin
            alarm_q <= 1'b1; // [RL10]
        end else if (alarm_clr) begin
            alarm_q <= 1'b0; // [RL10]
        end
    end

    // No hysteresis: a reading hovering at the limit makes the flag chatter,
    // so firmware should set the limit with some margin.
    // Over-temperature flag follows the comparison
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ot_q <= 1'b0;
        end else begin
            ot_q <= tmon_en && (temp_now >= temp_max_q); // [RL13]
        end
    end

    // Call-wide monitor: lead from the early warning, tail after last burst
    // The block cannot see the future, so the lead comes from the early-burst
    // warning that the radio core gives ahead of time. The tail is the
    // shortest allowed hang time, which keeps the pad honest about activity
    // while still bridging the gaps between bursts of one call.
    // One-hot states
    localparam ST_IDLE = 3'b001;
    localparam ST_LEAD = 3'b010;
    localparam ST_TAIL = 3'b100;
    reg [2:0] mst_q;
    reg [15:0] mtim_q;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mst_q <= ST_IDLE;
            mtim_q <= 16'h0000;
            mon_q <= 1'b0;
        end else if (mon_burst) begin
            // Burst mode bypasses the state machine entirely
            mst_q <= ST_IDLE;
            mon_q <= tx_burst; // [RL9]
        end else begin
            case (mst_q)
                ST_IDLE: begin
                    mon_q <= 1'b0;
                    // Warning arrives 300 ms ahead of the first burst
                    if (tx_burst_soon || tx_burst || call_active) begin
                        mon_q <= 1'b1; // [RL7]
                        mst_q <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    mon_q <= 1'b1; // [RL6]
                    mtim_q <= 16'h0000;
                    if (!call_active && !tx_burst && !tx_burst_soon) begin
                        mst_q <= ST_TAIL;
                    end
                end
                ST_TAIL: begin
                    // Tail timer restarts on any new burst
                    if (tx_burst || call_active) begin
                        mst_q <= ST_LEAD;
                    end else if (mtim_q == `MSP_MON_TAIL_MS) begin
                        mon_q <= 1'b0; // [RL8]
                        mst_q <= ST_IDLE;
                    end else if (ms_tick) begin
                        mtim_q <= mtim_q + 16'h0001;
                    end
                end
                default: mst_q <= ST_IDLE;
            endcase
        end
    end

    // Buzzer square wave, half period in core clocks
    // Tone pitch is set by software; cadence of rings and melodies is built
    // by toggling the enable.
    reg [15:0] bz_cnt_q;
    reg bz_q;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bz_cnt_q <= 16'h0000;
            bz_q <= 1'b0;
        end else if (!ctrl_q[`MSP_CTRL_BUZ_EN]) begin
            bz_cnt_q <= 16'h0000;
            bz_q <= 1'b0;
        end else if (bz_cnt_q >= buzz_half_q - 16'h0001) begin
            bz_cnt_q <= 16'h0000;
            bz_q <= ~bz_q; // [RL12]
        end else begin
            bz_cnt_q <= bz_cnt_q + 16'h0001;
        end
    end

    // Indicator blink timer in milliseconds
    // One shared counter serves both blink rates; a change of state may cut
    // one phase short, which an eye will not notice.
    reg [11:0] blk_q;
    reg led_q;
    // Period depends on the state being shown
    wire [11:0] blk_per = (net_state == `MSP_NET_REG) ? 12'd3000 : 12'd1000;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            blk_q <= 12'h000;
        end else if (ms_tick) begin
            blk_q <= (blk_q >= blk_per - 12'h001) ? 12'h000 : blk_q + 12'h001;
        end
    end
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            led_q <= 1'b0;
        end else begin
            // Indicator pattern per network state, registered to avoid glitches
            case (net_state)
                `MSP_NET_OFF: led_q <= 1'b0; // [RL15]
                `MSP_NET_CALL: led_q <= 1'b1; // [RL15]
                `MSP_NET_REG: led_q <= (blk_q < `MSP_BLINK_ON_MS); // [RL17]
                default: led_q <= (blk_q < `MSP_FAST_ON_MS); // [RL18]
            endcase
        end
    end
    assign network_status_indicator = ~led_q; // [RL16]

    // Pad mux: temperature pad overrides alternate function
    // Priority per pad: reset hold on the alarm pad, then temperature, then
    // the alternate function, then the plain output register.
    wire [7:0] alt_val;
    assign alt_val[`MSP_PAD_MON] = mon_q; // [RL5]
    assign alt_val[`MSP_PAD_ALM] = alarm_q;
    assign alt_val[`MSP_PAD_BUZ] = bz_q;
    assign alt_val[`MSP_PAD_TXI] = 1'b0;
    assign alt_val[1:0] = 2'b00;
    assign alt_val[7:6] = 2'b00;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pad
            // Pad index at the width of the select field
            localparam [2:0] PIDX = g;
            wire is_ot = ot_owns(tmon_en, tmon_pad, PIDX);
            wire alt_out = mode_q[g] && !is_ot && alt_drives(PIDX); // [RL14]
            // Alarm pad shows high while reset is held, whatever its mode
            wire rst_hi = (PIDX == `MSP_PAD_ALM) && !reset_n; // [RL11]
            assign pad_oe[g] = rst_hi || is_ot || alt_out || (!mode_q[g] && dir_q[g]);
            assign pad_out[g] = rst_hi || (is_ot ? ot_q : (alt_out ? alt_val[g] : out_q[g]));
        end
    endgenerate

    // Inhibit only when alternate mode is live and not lost to temp monitor.
    // The pin is synchronised first, so inhibit lags the pin by two clocks.
    localparam [2:0] TXI_IDX = `MSP_PAD_TXI;
    wire txi_live = mode_q[`MSP_PAD_TXI] && !ot_owns(tmon_en, tmon_pad, TXI_IDX);
    assign tx_enable = !(txi_live && !pad_s2_q[`MSP_PAD_TXI]); // [RL4]

    // Sticky events: bit0 alarm rise, bit1 overtemp rise, bit2 burst,
    // bit3 inhibit fall, bit4 pad 0 rise. Each edge detector (burst is a plain level and has none) has its own delay
    // stage, reset to the idle level of what it watches, so that leaving
    // reset does not look like an edge.
    reg ot_d1_q;
    reg txi_d1_q;
    reg alm_d1_q;
    reg p0_d1_q;
    wire ev_alarm = alarm_q && !alm_d1_q; // [RL10]
    wire ev_ot = ot_q && !ot_d1_q; // [RL13]
    wire ev_burst = tx_burst;
    wire ev_inhibit = txi_live && txi_d1_q && !pad_s2_q[`MSP_PAD_TXI]; // [RL4]
    wire ev_pad0 = pad_s2_q[0] && !p0_d1_q; // [RL1]
    wire [4:0] ev = {ev_pad0, ev_inhibit, ev_burst, ev_ot, ev_alarm};
    wire irq_rd = rd_en && (paddr == `MSP_OFF_IRQ);
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 5'h00;
            ot_d1_q <= 1'b0;
            txi_d1_q <= 1'b1;
            alm_d1_q <= 1'b1;
            p0_d1_q <= 1'b1;
        end else begin
            ot_d1_q <= ot_q;
            txi_d1_q <= pad_s2_q[`MSP_PAD_TXI];
            p0_d1_q <= pad_s2_q[0];
            alm_d1_q <= alarm_q;
            // New events win over the read clear
            irq_q <= (irq_rd ? 5'h00 : irq_q) | ev;
        end
    end
    // Level interrupt; status stays sticky even when masked
    assign irq = |(irq_q & mask_q);

    // Status snapshot, one bit per live function and two for the network state
    wire [7:0] stat_w = {led_q, ~tx_enable, ot_q, alarm_q, mon_q, net_state, bz_q};

    // Read mux; input pads show sampled level
    // Reads have no side effect except the interrupt status clear
    always @* begin
        case (paddr)
            `MSP_OFF_MODE: prdata = {24'h000000, mode_q};
            `MSP_OFF_DIR: prdata = {24'h000000, dir_q};
            `MSP_OFF_OUT: prdata = {24'h000000, out_q}; // [RL3]
            `MSP_OFF_IN: prdata = {24'h000000, pad_s2_q}; // [RL2]
            `MSP_OFF_CTRL: prdata = {25'h0000000, ctrl_q};
            `MSP_OFF_STAT: prdata = {24'h000000, stat_w};
            `MSP_OFF_IRQ: prdata = {27'h0000000, irq_q};
            `MSP_OFF_MASK: prdata = {27'h0000000, mask_q};
            `MSP_OFF_TEMP: prdata = {{(32-TEMP_W){1'b0}}, temp_max_q};
            `MSP_OFF_BUZZ: prdata = {16'h0000, buzz_half_q};
            default: prdata = 32'h0000_0000;
        endcase
    end

endmodule

// *** hw/msp_consts.vh ***
`ifndef MSP_CONSTS_VH
`define MSP_CONSTS_VH
// Register byte offsets
`define MSP_OFF_MODE 12'h000
`define MSP_OFF_DIR 12'h004
`define MSP_OFF_OUT 12'h008
`define MSP_OFF_IN 12'h00c
`define MSP_OFF_CTRL 12'h010
`define MSP_OFF_STAT 12'h014
`define MSP_OFF_IRQ 12'h018
`define MSP_OFF_MASK 12'h01c
`define MSP_OFF_TEMP 12'h020
`define MSP_OFF_BUZZ 12'h024
// Pad numbering within the 8-bit pad group
`define MSP_PAD_TXI 2
`define MSP_PAD_MON 3
`define MSP_PAD_ALM 4
`define MSP_PAD_BUZ 5
// CTRL fields
`define MSP_CTRL_MON_BURST 0
`define MSP_CTRL_ALM_CLR 1
`define MSP_CTRL_TMON_EN 2
`define MSP_CTRL_TMON_PAD_LO 3
`define MSP_CTRL_TMON_PAD_HI 5
`define MSP_CTRL_BUZ_EN 6
// Indicator state codes
`define MSP_NET_OFF 2'h0
`define MSP_NET_SEARCH 2'h1
`define MSP_NET_REG 2'h2
`define MSP_NET_CALL 2'h3
// Timing, in milliseconds, and clock rate
`define MSP_CLK_HZ 250000000
`define MSP_MS_CYCLES (`MSP_CLK_HZ / 1000)
`define MSP_MON_LEAD_MS 300
`define MSP_MON_TAIL_MS 500
`define MSP_MON_TAIL_MAX_MS 1000
`define MSP_BLINK_PERIOD_MS 3000
`define MSP_BLINK_ON_MS 300
`define MSP_FAST_PERIOD_MS 1000
`define MSP_FAST_ON_MS 500
`endif

// *** testbench/msp_status_pins_asserts.sv ***
`timescale 1ns/1ps
`include "msp_consts.vh"
module msp_status_pins_asserts #(
    parameter MS_CYCLES = 4,
    parameter TEMP_W = 8
) (
    input wire core_clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire [7:0] pad_out,
    input wire [1:0] net_state,
    input wire network_status_indicator
);
    wire acc = psel && penable;
    wire bad = (paddr > `MSP_OFF_BUZZ) || (paddr[1:0] != 2'h0);
    wire reg_st = (net_state == `MSP_NET_REG);
    reg [7:0] out_q;
    reg [31:0] lit_q;
    reg [31:0] dark_q;
    // Shadow of the output register and lengths of the blink phases
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_q <= 8'h00;
            lit_q <= 32'h0;
            dark_q <= 32'h0;
        end else begin
            if (acc && pwrite && paddr == `MSP_OFF_OUT)
                out_q <= pwdata[7:0];
            lit_q <= (reg_st && !network_status_indicator) ? lit_q + 32'h1 : 32'h0;
            dark_q <= (reg_st && network_status_indicator) ? dark_q + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_call;
        (net_state == `MSP_NET_CALL) [*3];
    endsequence
    sequence s_off;
        (net_state == `MSP_NET_OFF) [*3];
    endsequence
    AST_RD_UNMAPPED: assert property (acc && !pwrite && bad |-> prdata == 32'h0 && pslverr)
        else $error("unmapped read not refused");
    AST_OUT_READBACK: assert property (acc && !pwrite && paddr == `MSP_OFF_OUT |-> prdata[7:0] == out_q)
        else $error("output register readback differs");
    AST_MAPPED_OK: assert property (acc && !bad |-> !pslverr)
        else $error("mapped access refused");
    AST_IND_CALL: assert property (s_call |-> !network_status_indicator)
        else $error("indicator pin not low during call");
    AST_IND_OFF: assert property (s_off |-> network_status_indicator)
        else $error("indicator pin not high when off");
    // Reset itself is the cause here, so this one is never disabled
    AST_ALARM_RESET: assert property (disable iff (1'b0) !reset_n |-> pad_out[4])
        else $error("alarm pad low in reset");
    AST_BLINK_ON: assert property (lit_q <= 300 * MS_CYCLES + 2)
        else $error("slow blink on-time too long");
    AST_BLINK_OFF: assert property (dark_q <= 2700 * MS_CYCLES + 2)
        else $error("slow blink off-time too long");
endmodule
bind msp_status_pins msp_status_pins_asserts #(.MS_CYCLES(MS_CYCLES), .TEMP_W(TEMP_W)) chk_u (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .pad_out(pad_out),
    .net_state(net_state), .network_status_indicator(network_status_indicator));

// *** testbench/msp_pad_partner.sv ***
`timescale 1ns/1ps
module msp_pad_partner (
    input wire [7:0] pad_out,
    input wire [7:0] pad_oe,
    input wire [7:0] host_drive,
    input wire [7:0] host_en,
    input wire network_status_indicator,
    output wire [7:0] pad_in,
    output wire led_lit
);
    // Host drives enabled pads; external pull-ups hold released pads high
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & (~host_en | host_drive));
    // Inverting transistor lights the lamp while the pin is low
    assign led_lit = ~network_status_indicator;
endmodule

// *** testbench/msp_status_pins_tb_top.sv ***
`timescale 1ns/1ps
`include "msp_consts.vh"
module msp_status_pins_tb_top;
    localparam MS = 4;
    reg core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg call_active = 1'b0, tx_burst = 1'b0, tx_burst_soon = 1'b0, alarm_due = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [7:0] temp_now = 8'h00, host_drive = 8'hff, host_en = 8'h00;
    reg [1:0] net_state = 2'h0;
    wire [31:0] prdata;
    wire pready, pslverr, tx_enable, ind, irq, led_lit;
    wire [7:0] pad_in, pad_out, pad_oe;
    integer seed = 22, miscompares = 0, total_checks = 0, n;
    reg e, p;
    reg [31:0] r, v;
    msp_status_pins #(.MS_CYCLES(MS)) dut_u (.core_clk(core_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .call_active(call_active), .tx_burst(tx_burst),
        .tx_burst_soon(tx_burst_soon), .alarm_due(alarm_due), .temp_now(temp_now),
        .net_state(net_state), .tx_enable(tx_enable), .network_status_indicator(ind),
        .irq(irq));
    msp_pad_partner host_u (.pad_out(pad_out), .pad_oe(pad_oe), .host_drive(host_drive),
        .host_en(host_en), .network_status_indicator(ind), .pad_in(pad_in), .led_lit(led_lit));
    initial forever #2 core_clk = ~core_clk;
    // Milliseconds to clock cycles at the shortened time base
    function integer ms(input integer k);
        ms = k * MS;
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge core_clk);
    endtask
    // One APB transfer; read data taken at the completing edge
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'b1;
            @(posedge core_clk);
            while (pready !== 1'b1) @(posedge core_clk);
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task conclude;
        begin
            $display("checks %0d miscompares %0d", total_checks, miscompares);
            if (miscompares == 0 && total_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // Watchdog sized well beyond the longest blink measurement
    initial begin
        cyc(60000);
        miscompares = miscompares + 1;
        conclude;
    end
    initial begin
        cyc(20);
        chk({ind, tx_enable, irq, pad_out[4]}, 4'hd);
        reset_n <= 1'b1;
        v = $random(seed);
        apb(1, `MSP_OFF_DIR, 32'hff);
        apb(1, `MSP_OFF_OUT, v);
        apb(0, `MSP_OFF_OUT, 32'h0);
        chk(r[7:0], v[7:0]);
        chk({pad_oe, pad_out}, {8'hff, v[7:0]});
        apb(1, `MSP_OFF_DIR, 32'h0);
        host_en <= 8'hff;
        host_drive <= v[15:8];
        cyc(4);
        apb(0, `MSP_OFF_IN, 32'h0);
        chk(r[7:0], v[15:8]);
        apb(0, 12'h030, 32'h0);
        chk({e, r}, {1'b1, 32'h0});
        // Alternate functions on pads 2 to 5; host keeps only the inhibit line
        host_en <= 8'h04;
        host_drive <= 8'h00;
        apb(1, `MSP_OFF_MODE, 32'h3c);
        cyc(4);
        chk(tx_enable, 0);
        host_drive <= 8'h04;
        cyc(4);
        chk(tx_enable, 1);
        apb(1, `MSP_OFF_CTRL, 32'h1);
        tx_burst <= 1'b1;
        cyc(2);
        chk(pad_out[3], 1);
        tx_burst <= 1'b0;
        cyc(2);
        chk(pad_out[3], 0);
        // Call-wide mode: lead, hold through bursts, tail
        apb(1, `MSP_OFF_CTRL, 32'h0);
        cyc(4);
        chk(pad_out[3], 0);
        tx_burst_soon <= 1'b1;
        cyc(2);
        chk(pad_out[3], 1);
        tx_burst_soon <= 1'b0;
        call_active <= 1'b1;
        repeat (3) begin
            tx_burst <= 1'b1;
            cyc(3);
            tx_burst <= 1'b0;
            cyc(8);
            chk(pad_out[3], 1);
        end
        tx_burst <= 1'b1;
        cyc(3);
        tx_burst <= 1'b0;
        call_active <= 1'b0;
        cyc(ms(500) - 10);
        chk(pad_out[3], 1);
        cyc(ms(500) + 20);
        chk(pad_out[3], 0);
        // Alarm latches, raises the interrupt, clears on command
        apb(1, `MSP_OFF_CTRL, 32'h2);
        apb(1, `MSP_OFF_MASK, 32'h1);
        for (n = 0; n < 2; n = n + 1) begin
            alarm_due <= 1'b1;
            cyc(1);
            alarm_due <= 1'b0;
            cyc(20);
            chk({pad_out[4], irq}, {1'b1, n == 0});
            apb(0, `MSP_OFF_IRQ, 32'h0);
            chk(r[0], 1);
            cyc(1);
            chk(irq, 0);
            apb(1, `MSP_OFF_CTRL, 32'h2);
            cyc(2);
            chk(pad_out[4], 0);
            apb(1, `MSP_OFF_MASK, 32'h0);
        end
        // Buzzer toggles at the programmed half period
        apb(1, `MSP_OFF_BUZZ, 32'h3);
        apb(1, `MSP_OFF_CTRL, 32'h40);
        n = 0;
        p = pad_out[5];
        repeat (60) begin
            @(posedge core_clk);
            if (pad_out[5] !== p)
                n = n + 1;
            p = pad_out[5];
        end
        chk(n >= 15 && n <= 21, 1);
        // Over-temperature takes pad 3 away from the monitor
        v = $random(seed);
        apb(1, `MSP_OFF_TEMP, {24'h0, v[7:0] | 8'h01});
        temp_now <= (v[7:0] | 8'h01) - 8'h01;
        apb(1, `MSP_OFF_CTRL, 32'h1c);
        tx_burst_soon <= 1'b1;
        cyc(3);
        chk(pad_out[3], 0);
        temp_now <= v[7:0] | 8'h01;
        cyc(3);
        chk(pad_out[3], 1);
        net_state <= `MSP_NET_CALL;
        cyc(5);
        chk({ind, led_lit}, 2'h1);
        // Lit time over one blink period, registered then searching
        net_state <= `MSP_NET_REG;
        cyc(2);
        n = 0;
        repeat (ms(3000)) @(posedge core_clk) n = n + (led_lit === 1'b1);
        chk(n >= ms(300) - 2 && n <= ms(300) + 2, 1);
        net_state <= `MSP_NET_SEARCH;
        cyc(2);
        n = 0;
        repeat (ms(1000)) @(posedge core_clk) n = n + (led_lit === 1'b1);
        chk(n > ms(300) + 10 && n < ms(1000), 1);
        conclude;
    end
endmodule
